// *** src/bsc_regs.vh ***
// register map, field positions, reset values and timing of the bin sorting comparator
`ifndef BSC_REGS_VH
`define BSC_REGS_VH

`define BSC_ADR_W          8
`define BSC_CTRL           8'h00
`define BSC_BIN_EN         8'h04
`define BSC_SEC_CTRL       8'h08
`define BSC_LO_NOLIM       8'h0C
`define BSC_HI_NOLIM       8'h10
`define BSC_REF            8'h14
`define BSC_PRI_MEAS       8'h18
`define BSC_SEC_MEAS       8'h1C
`define BSC_RESULT         8'h20
`define BSC_IRQ_STAT       8'h24
`define BSC_IRQ_MASK       8'h28
`define BSC_SEC_LO         8'h2C
`define BSC_SEC_HI         8'h30
`define BSC_BIN_LO_BASE    8'h40
`define BSC_BIN_HI_BASE    8'h80
`define BSC_BIN_AREA_MASK  8'hC0

`define BSC_CTRL_SORT      0
`define BSC_CTRL_LIMIT     1
`define BSC_CTRL_FMT_LSB   2
`define BSC_CTRL_BEEP_LSB  4
`define BSC_SEC_EN         0
`define BSC_SEC_LO_NL      1
`define BSC_SEC_HI_NL      2

`define BSC_FMT_RAW        2'h0
`define BSC_FMT_DEV        2'h1
`define BSC_FMT_DEVPCT     2'h2
`define BSC_BEEP_OFF       2'h0
`define BSC_BEEP_FAIL      2'h1
`define BSC_BEEP_PASS      2'h2

`define BSC_RES_BIN_LSB    0
`define BSC_RES_NOBIN      4
`define BSC_RES_PBELOW     5
`define BSC_RES_PIN        6
`define BSC_RES_PABOVE     7
`define BSC_RES_SBELOW     8
`define BSC_RES_SIN        9
`define BSC_RES_SABOVE     10
`define BSC_RES_SFAIL      11
`define BSC_RES_PASS       12
`define BSC_RES_BUSY       16

`define BSC_IRQ_DONE       0
`define BSC_IRQ_FAIL       1
`define BSC_IRQ_SFAIL      2

`define BSC_CTRL_RST       6'h00
`define BSC_BIN_EN_RST     14'h0001
`define BSC_NOLIM_RST      14'h3FFF
`define BSC_SEC_CTRL_RST   3'h7
`define BSC_LIMIT_RST      32'h00000000
`define BSC_PCT_SCALE      8'h64

`define BSC_CLK_PS         5000
`define BSC_BEEP_NS        50000000
`define BSC_BEEP_CYCLES    (`BSC_BEEP_NS / (`BSC_CLK_PS / 1000))

`endif

// *** src/bsc_range_cmp.v ***
// one low/high range check with enable, no-limit flags and optional limit scaling
`timescale 1ns/1ps
module bsc_range_cmp #(
  parameter VW = 32,
  parameter XW = 66
) (
  input  wire signed [XW-1:0] val_i,
  input  wire signed [VW-1:0] lo_i,
  input  wire signed [VW-1:0] hi_i,
  input  wire signed [VW-1:0] ref_i,
  input  wire                 scale_i,
  input  wire                 en_i,
  input  wire                 lo_nl_i,
  input  wire                 hi_nl_i,
  output wire                 active_o,
  output wire                 below_o,
  output wire                 inside_o,
  output wire                 above_o
);
  // percent mode moves the scaling onto the limits to avoid a divider
  wire signed [XW-1:0] lo_x   = {{(XW-VW){lo_i[VW-1]}}, lo_i};
  wire signed [XW-1:0] hi_x   = {{(XW-VW){hi_i[VW-1]}}, hi_i};
  wire signed [XW-1:0] ref_x  = {{(XW-VW){ref_i[VW-1]}}, ref_i};
  wire signed [XW-1:0] lo_eff = scale_i ? lo_x * ref_x : lo_x;
  wire signed [XW-1:0] hi_eff = scale_i ? hi_x * ref_x : hi_x;
  wire                 both_on = ~lo_nl_i & ~hi_nl_i;

  assign active_o = en_i & ~(lo_nl_i & hi_nl_i)           // R3 R7 R8
                  & ~(both_on & (lo_i >= hi_i));          // R5
  assign below_o  = active_o & ~lo_nl_i & (val_i < lo_eff);   // R6 R15
  assign above_o  = active_o & ~hi_nl_i & (val_i > hi_eff);   // R6 R15
  assign inside_o = active_o & ~below_o & ~above_o;           // R15
endmodule // bsc_range_cmp

// *** src/bsc_beeper.v ***
// beeper that sounds for a fixed time after a judgement, per pass/fail policy
`timescale 1ns/1ps
`include "bsc_regs.vh"
module bsc_beeper #(
  parameter BEEP_CYCLES = 10000000,
  parameter CW          = 24
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       fire_i,
  input  wire       pass_i,
  input  wire [1:0] mode_i,
  output reg        beep_o
);
  reg  [CW-1:0] cnt_q;
  wire          want = (mode_i == `BSC_BEEP_FAIL & ~pass_i)
                     | (mode_i == `BSC_BEEP_PASS &  pass_i);      // R11

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= {CW{1'b0}};
      beep_o <= 1'b0;
    end
    else if (mode_i == `BSC_BEEP_OFF)
    begin
      cnt_q  <= {CW{1'b0}};                                       // R11
      beep_o <= 1'b0;
    end
    else if (fire_i && want)
    begin
      cnt_q  <= BEEP_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      beep_o <= 1'b1;
    end
    else if (cnt_q != {CW{1'b0}})
      cnt_q  <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
    else
      beep_o <= 1'b0;
  end
endmodule // bsc_beeper

// *** src/bsc_top.v ***
// bin sorting / limit comparator with wishbone registers, interrupt and beeper
// Function
// R1 - scan bins ascending, lowest matching bin wins
// R2 - no bin matched reports out-of-range
// R3 - each bin has enable; disabled never chosen
// R4 - all bins disabled always out-of-range
// R5 - lower at or above upper never matches
// R6 - per-limit no-limit flag skips that side
// R7 - bin with both no-limit acts disabled
// R8 - secondary both no-limit acts disabled
// R9 - disabled secondary drives no secondary results
// R10 - limits are signed values
// R11 - beeper mode off, fail or pass
// R12 - sorting: bins pass, anything else fails
// R13 - limit mode: only in-range passes
// R14 - deviation formats compare difference from reference
// R15 - equal to limit counts as inside
`timescale 1ns/1ps
`include "bsc_regs.vh"
module bsc_top #(
  parameter NBIN        = 14,
  parameter VW          = 32,
  parameter BEEP_CYCLES = `BSC_BEEP_CYCLES
) (
  input  wire                   clk_i,
  input  wire                   rst_i,
  input  wire [`BSC_ADR_W-1:0]  adr_i,
  input  wire [31:0]            dat_i,
  output reg  [31:0]            dat_o,
  input  wire                   we_i,
  input  wire [3:0]             sel_i,
  input  wire                   cyc_i,
  input  wire                   stb_i,
  output reg                    ack_o,
  output reg                    irq_o,
  output wire                   beep_o,
  output reg  [NBIN-1:0]        bin_hit_o,
  output reg                    no_bin_match_o,
  output reg                    pri_below_o,
  output reg                    pri_in_o,
  output reg                    pri_above_o,
  output reg                    second_param_below_o,
  output reg                    second_param_in_o,
  output reg                    second_param_above_o,
  output reg                    second_param_fail_o,
  output reg                    judge_done_o
);
  localparam XW       = 2 * VW + 2;
  localparam ST_IDLE  = 2'h0;
  localparam ST_PREP  = 2'h1;
  localparam ST_SCAN  = 2'h2;
  localparam ST_DONE  = 2'h3;

  reg  [5:0]           ctrl_q;
  reg  [NBIN-1:0]      bin_en_q;
  reg  [2:0]           sec_ctrl_q;
  reg  [NBIN-1:0]      lo_nl_q;
  reg  [NBIN-1:0]      hi_nl_q;
  reg  [VW-1:0]        ref_q;
  reg  [VW-1:0]        pmeas_q;
  reg  [VW-1:0]        smeas_q;
  reg  [VW-1:0]        sec_lo_q;
  reg  [VW-1:0]        sec_hi_q;
  reg  [VW-1:0]        lo_q [0:NBIN-1];
  reg  [VW-1:0]        hi_q [0:NBIN-1];
  reg  [2:0]           stat_q;
  reg  [2:0]           mask_q;
  reg  [1:0]           st_q;
  reg  [3:0]           idx_q;
  reg  signed [XW-1:0] x_q;
  reg                  limit_run_q;
  reg  [16:0]          result_q;
  reg                  fire_q;
  reg                  pass_q;
  reg  [31:0]          rd_d;

  wire       wb_req  = cyc_i & stb_i & ~ack_o;
  wire       wb_wr   = wb_req & we_i;
  wire       in_bins = (adr_i & `BSC_BIN_AREA_MASK) == `BSC_BIN_LO_BASE
                     | (adr_i & `BSC_BIN_AREA_MASK) == `BSC_BIN_HI_BASE;
  wire [3:0] wb_idx  = adr_i[5:2];
  // a write merges its lanes into the addressed register's current value
  wire [31:0] wr_m   = {sel_i[3] ? dat_i[31:24] : rd_d[31:24],
                        sel_i[2] ? dat_i[23:16] : rd_d[23:16],
                        sel_i[1] ? dat_i[15:8]  : rd_d[15:8],
                        sel_i[0] ? dat_i[7:0]   : rd_d[7:0]};
  wire [1:0] fmt     = ctrl_q[`BSC_CTRL_FMT_LSB +: 2];
  wire       run_en  = ctrl_q[`BSC_CTRL_SORT] | ctrl_q[`BSC_CTRL_LIMIT];
  // a new part is only accepted while idle; a write while busy is dropped and the old value kept
  wire       start   = wb_wr & (adr_i == `BSC_PRI_MEAS) & (st_q == ST_IDLE) & run_en;

  genvar g;
  generate
    for (g = 0; g < NBIN; g = g + 1)
    begin : g_lim
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          lo_q[g] <= `BSC_LIMIT_RST;
          hi_q[g] <= `BSC_LIMIT_RST;
        end
        else if (wb_wr && in_bins && wb_idx == g)
        begin
          if (adr_i[7])
            hi_q[g] <= wr_m[VW-1:0];                              // R10
          else
            lo_q[g] <= wr_m[VW-1:0];                              // R10
        end
      end
    end
  endgenerate

  // shared range check walks the bins, one per cycle
  wire [3:0]  cur = (st_q == ST_SCAN) ? idx_q : 4'h0;
  wire        p_en = limit_run_q ? 1'b1 : bin_en_q[cur];           // R3
  wire        p_act;
  wire        p_below;
  wire        p_in;
  wire        p_above;
  wire        s_act;
  wire        s_below;
  wire        s_in;
  wire        s_above;

  bsc_range_cmp #(
    .VW (VW),
    .XW (XW)
  ) u_pri (
    .val_i    (x_q),
    .lo_i     (lo_q[cur]),
    .hi_i     (hi_q[cur]),
    .ref_i    (ref_q),
    .scale_i  (fmt == `BSC_FMT_DEVPCT),                           // R14
    .en_i     (p_en),
    .lo_nl_i  (lo_nl_q[cur]),
    .hi_nl_i  (hi_nl_q[cur]),
    .active_o (p_act),
    .below_o  (p_below),
    .inside_o (p_in),
    .above_o  (p_above)
  );

  bsc_range_cmp #(
    .VW (VW),
    .XW (XW)
  ) u_sec (
    .val_i    ({{(XW-VW){smeas_q[VW-1]}}, smeas_q}),
    .lo_i     (sec_lo_q),
    .hi_i     (sec_hi_q),
    .ref_i    (ref_q),
    .scale_i  (1'b0),
    .en_i     (sec_ctrl_q[`BSC_SEC_EN]),
    .lo_nl_i  (sec_ctrl_q[`BSC_SEC_LO_NL]),
    .hi_nl_i  (sec_ctrl_q[`BSC_SEC_HI_NL]),
    .active_o (s_act),
    .below_o  (s_below),
    .inside_o (s_in),
    .above_o  (s_above)
  );

  // deviation percent keeps a factor of reference on the limits instead of dividing
  wire signed [XW-1:0] pm_x  = {{(XW-VW){pmeas_q[VW-1]}}, pmeas_q};
  wire signed [XW-1:0] ref_x = {{(XW-VW){ref_q[VW-1]}}, ref_q};
  wire signed [XW-1:0] dev_w = pm_x - ref_x;                                     // R14
  wire signed [XW-1:0] pct_w = dev_w * $signed({{(XW-8){1'b0}}, `BSC_PCT_SCALE}); // R14

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q        <= ST_IDLE;
      idx_q       <= 4'h0;
      x_q         <= {XW{1'b0}};
      limit_run_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (start)
          begin
            st_q        <= ST_PREP;
            limit_run_q <= ctrl_q[`BSC_CTRL_LIMIT];
          end
        ST_PREP:
        begin
          if (fmt == `BSC_FMT_DEV)
            x_q <= dev_w;                                          // R14
          else if (fmt == `BSC_FMT_DEVPCT)
            x_q <= pct_w;                                          // R14
          else
            x_q <= pm_x;
          idx_q <= 4'h0;
          st_q  <= ST_SCAN;
        end
        ST_SCAN:
        begin
          if (limit_run_q)
            st_q <= ST_DONE;
          else if (p_in)
            st_q <= ST_DONE;                                       // R1
          else if (idx_q == NBIN - 1)
            st_q <= ST_DONE;                                       // R2 R4
          else
            idx_q <= idx_q + 4'h1;                                 // R1
        end
        ST_DONE:
          st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // results latch in the scan cycle that ends, and stay until the next part
  wire       ending   = (st_q == ST_SCAN) & (limit_run_q | p_in | idx_q == NBIN - 1);
  wire       won      = ~limit_run_q & p_in;
  wire       s_fail   = s_act & ~s_in;                             // R9
  wire       pass_now = limit_run_q ? (p_in & ~s_fail) : won;      // R12 R13
  wire [3:0] bin_num  = idx_q + 4'h1;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bin_hit_o            <= {NBIN{1'b0}};
      no_bin_match_o       <= 1'b0;
      pri_below_o          <= 1'b0;
      pri_in_o             <= 1'b0;
      pri_above_o          <= 1'b0;
      second_param_below_o <= 1'b0;
      second_param_in_o    <= 1'b0;
      second_param_above_o <= 1'b0;
      second_param_fail_o  <= 1'b0;
      judge_done_o         <= 1'b0;
      fire_q               <= 1'b0;
      pass_q               <= 1'b0;
      result_q             <= 17'h00000;
    end
    else
    begin
      judge_done_o <= ending;
      fire_q       <= ending;
      if (ending)
      begin
        bin_hit_o            <= won ? ({{(NBIN-1){1'b0}}, 1'b1} << idx_q) : {NBIN{1'b0}};
        no_bin_match_o       <= ~limit_run_q & ~p_in;                       // R2
        pri_below_o          <= limit_run_q & p_below;
        pri_in_o             <= limit_run_q & p_in;
        pri_above_o          <= limit_run_q & p_above;
        second_param_below_o <= s_below;                                    // R9
        second_param_in_o    <= s_in;                                       // R9
        second_param_above_o <= s_above;                                    // R9
        second_param_fail_o  <= s_fail;                                     // R9
        pass_q               <= pass_now;
        result_q             <= {1'b0, 3'h0, pass_now, s_fail, s_above, s_in, s_below,
                                 limit_run_q & p_above, limit_run_q & p_in,
                                 limit_run_q & p_below, ~limit_run_q & ~p_in,
                                 won ? bin_num : 4'h0};
      end
    end
  end

  bsc_beeper #(
    .BEEP_CYCLES (BEEP_CYCLES),
    .CW          (32)
  ) u_beep (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .fire_i (fire_q),
    .pass_i (pass_q),
    .mode_i (ctrl_q[`BSC_CTRL_BEEP_LSB +: 2]),
    .beep_o (beep_o)
  );

  // register writes; status set by a judgement wins over a same-cycle clear
  wire [2:0] ev = {ending & s_fail, ending & ~pass_now, ending};
  wire [2:0] clr = (wb_wr && adr_i == `BSC_IRQ_STAT && sel_i[0]) ? dat_i[2:0] : 3'h0;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q     <= `BSC_CTRL_RST;
      bin_en_q   <= `BSC_BIN_EN_RST;
      sec_ctrl_q <= `BSC_SEC_CTRL_RST;
      lo_nl_q    <= `BSC_NOLIM_RST;
      hi_nl_q    <= `BSC_NOLIM_RST;
      ref_q      <= `BSC_LIMIT_RST;
      pmeas_q    <= `BSC_LIMIT_RST;
      smeas_q    <= `BSC_LIMIT_RST;
      sec_lo_q   <= `BSC_LIMIT_RST;
      sec_hi_q   <= `BSC_LIMIT_RST;
      stat_q     <= 3'h0;
      mask_q     <= 3'h0;
      irq_o      <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~clr) | ev;
      irq_o  <= |(((stat_q & ~clr) | ev) & mask_q);
      if (wb_wr)
      begin
        case (adr_i)
          `BSC_CTRL:     ctrl_q     <= wr_m[5:0];
          `BSC_BIN_EN:   bin_en_q   <= wr_m[NBIN-1:0];
          `BSC_SEC_CTRL: sec_ctrl_q <= wr_m[2:0];
          `BSC_LO_NOLIM: lo_nl_q    <= wr_m[NBIN-1:0];
          `BSC_HI_NOLIM: hi_nl_q    <= wr_m[NBIN-1:0];
          `BSC_REF:      ref_q      <= wr_m[VW-1:0];
          `BSC_PRI_MEAS: pmeas_q    <= (st_q == ST_IDLE) ? wr_m[VW-1:0] : pmeas_q;
          `BSC_SEC_MEAS: smeas_q    <= (st_q == ST_IDLE) ? wr_m[VW-1:0] : smeas_q;
          `BSC_SEC_LO:   sec_lo_q   <= wr_m[VW-1:0];                        // R10
          `BSC_SEC_HI:   sec_hi_q   <= wr_m[VW-1:0];                        // R10
          `BSC_IRQ_MASK: mask_q     <= sel_i[0] ? dat_i[2:0] : mask_q;
          default:       mask_q     <= mask_q;
        endcase
      end
    end
  end

  // read path and one-cycle acknowledge; unmapped reads return zero

  always @*
  begin
    rd_d = 32'h00000000;
    if (in_bins && wb_idx < NBIN)
      rd_d = adr_i[7] ? hi_q[wb_idx] : lo_q[wb_idx];
    else
    begin
      case (adr_i)
        `BSC_CTRL:     rd_d = {26'h0, ctrl_q};
        `BSC_BIN_EN:   rd_d = {18'h0, bin_en_q};
        `BSC_SEC_CTRL: rd_d = {29'h0, sec_ctrl_q};
        `BSC_LO_NOLIM: rd_d = {18'h0, lo_nl_q};
        `BSC_HI_NOLIM: rd_d = {18'h0, hi_nl_q};
        `BSC_REF:      rd_d = ref_q;
        `BSC_PRI_MEAS: rd_d = pmeas_q;
        `BSC_SEC_MEAS: rd_d = smeas_q;
        `BSC_RESULT:   rd_d = {15'h0, st_q != ST_IDLE, result_q[15:0]};
        `BSC_IRQ_STAT: rd_d = {29'h0, stat_q};
        `BSC_IRQ_MASK: rd_d = {29'h0, mask_q};
        `BSC_SEC_LO:   rd_d = sec_lo_q;
        `BSC_SEC_HI:   rd_d = sec_hi_q;
        default:       rd_d = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= wb_req;
      dat_o <= wb_req ? rd_d : 32'h00000000;
    end
  end
endmodule // bsc_top

// *** verif/bsc_operator.sv ***
// wishbone master standing in for the operator who enters limits
`timescale 1ns/1ps
module bsc_operator (
  input  wire        clk_i,
  input  wire        ack_i,
  input  wire [31:0] dat_i,
  output reg  [7:0]  adr_o,
  output reg  [31:0] dat_o,
  output reg         we_o,
  output reg  [3:0]  sel_o,
  output reg         cyc_o,
  output reg         stb_o
);
  reg hung_q;
  initial
  begin
    {adr_o, dat_o, we_o, sel_o, cyc_o, stb_o} = 47'h0;
    hung_q = 1'b0;
  end
  // gap idles first so a slow operator is exercised as well as a prompt one
  task acc(input w, input [7:0] a, input [31:0] d, input integer gap, output [31:0] q);
    integer n;
    begin
      repeat (gap + 1) @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, dat_o, sel_o} <= {1'b1, 1'b1, w, a, d, 4'hF};
      n = 0;
      @(posedge clk_i);
      while (ack_i !== 1'b1 && n < 50)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      // answer taken at the edge that samples ack high, then released
      hung_q = (n >= 50);
      q = dat_i;
      // released lines show junk, not the last value
      {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b00, ~we_o, ~adr_o, ~dat_o};
    end
  endtask
endmodule // bsc_operator

// *** verif/bsc_top_assertions.sv ***
// concurrent checks on the comparator's ports
`timescale 1ns/1ps
module bsc_top_assertions #(
  parameter NBIN = 14
) (
  input wire            clk_i,
  input wire            rst_i,
  input wire            cyc_i,
  input wire            stb_i,
  input wire            ack_o,
  input wire [31:0]     dat_o,
  input wire            beep_o,
  input wire [NBIN-1:0] bin_hit_o,
  input wire            no_bin_match_o,
  input wire            pri_below_o,
  input wire            pri_in_o,
  input wire            pri_above_o,
  input wire            second_param_below_o,
  input wire            second_param_in_o,
  input wire            second_param_above_o,
  input wire            second_param_fail_o,
  input wire            judge_done_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_timing: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse one cycle after request");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  chk_done_pulse: assert property (judge_done_o |=> !judge_done_o)
    else $error("done longer than one cycle");
  chk_bin_onehot: assert property (bin_hit_o != 0 |-> $onehot(bin_hit_o) && !no_bin_match_o)
    else $error("bin result not one-hot or also out of range");
  chk_done_result: assert property (judge_done_o |-> bin_hit_o != 0 || no_bin_match_o ||
    pri_below_o || pri_in_o || pri_above_o)
    else $error("judgement without any result");
  chk_pri_only: assert property (pri_below_o || pri_in_o || pri_above_o |->
    $onehot({pri_below_o, pri_in_o, pri_above_o}) && bin_hit_o == 0 && !no_bin_match_o)
    else $error("limit result mixed with bin result");
  chk_sec_fail: assert property (second_param_fail_o ==
    (second_param_below_o || second_param_above_o))
    else $error("secondary fail disagrees with secondary range");
  chk_result_hold: assert property (!judge_done_o |-> $stable({bin_hit_o, no_bin_match_o,
    pri_below_o, pri_in_o, pri_above_o, second_param_below_o, second_param_in_o,
    second_param_above_o, second_param_fail_o}))
    else $error("result changed without a judgement");
  chk_beep_start: assert property ($rose(beep_o) |-> $past(judge_done_o))
    else $error("beeper started without a judgement");
endmodule // bsc_top_assertions

bind bsc_top bsc_top_assertions #(.NBIN(NBIN)) bsc_top_assertions_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .dat_o(dat_o), .beep_o(beep_o), .bin_hit_o(bin_hit_o), .no_bin_match_o(no_bin_match_o),
  .pri_below_o(pri_below_o), .pri_in_o(pri_in_o), .pri_above_o(pri_above_o),
  .second_param_below_o(second_param_below_o), .second_param_in_o(second_param_in_o),
  .second_param_above_o(second_param_above_o),
  .second_param_fail_o(second_param_fail_o), .judge_done_o(judge_done_o));

// *** verif/bin_sort_comparator_tb.sv ***
// self-checking bench for the bin sorting comparator
`timescale 1ns/1ps
`include "bsc_regs.vh"
`define TB_CHK(got, exp, msg) \
  begin \
    checks = checks + 1; \
    if ((got) !== (exp)) \
    begin \
      fails = fails + 1; \
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp); \
    end \
  end
module bin_sort_comparator_tb;
  typedef struct packed {logic [1:0] beep; logic [31:0] meas; logic [3:0] bin;} bsc_row_t;
  reg         clk_i, rst_i;
  wire [7:0]  adr;
  wire [31:0] wdat, rdat;
  wire [3:0]  sel;
  wire [13:0] bin_hit;
  wire        we, cyc, stb, ack, irq, beep, no_match, pri_b, pri_n, pri_a;
  wire        sec_b, sec_n, sec_a, sec_f, done;
  integer     fails, checks, i;
  reg  [31:0] q, lo_v [0:5], hi_v [0:5];
  bsc_row_t   rows [0:7];
  bsc_row_t   r;

  bsc_operator bsc_operator_i (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .adr_o(adr),
    .dat_o(wdat), .we_o(we), .sel_o(sel), .cyc_o(cyc), .stb_o(stb));
  bsc_top #(.BEEP_CYCLES(8)) bsc_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack), .irq_o(irq), .beep_o(beep), .bin_hit_o(bin_hit), .no_bin_match_o(no_match),
    .pri_below_o(pri_b), .pri_in_o(pri_n), .pri_above_o(pri_a), .second_param_below_o(sec_b),
    .second_param_in_o(sec_n), .second_param_above_o(sec_a), .second_param_fail_o(sec_f),
    .judge_done_o(done));

  always #2.5 clk_i = ~clk_i;

  task summarize;
    begin
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  always @(posedge bsc_operator_i.hung_q)
  begin
    fails = fails + 1;
    summarize;
  end

  task wr(input [7:0] a, input [31:0] d);
    bsc_operator_i.acc(1'b1, a, d, 0, q);
  endtask

  task rd(input [7:0] a);
    bsc_operator_i.acc(1'b0, a, 32'h0, 1, q);
  endtask

  // returns at the settled half of the done cycle
  task judge(input [31:0] m);
    integer n;
    begin
      wr(`BSC_PRI_MEAS, m);
      n = 0;
      while (done !== 1'b1 && n < 40)
      begin
        @(negedge clk_i);
        n = n + 1;
      end
      if (n >= 40)
      begin
        fails = fails + 1;
        summarize;
      end
    end
  endtask

  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    fails = 0;
    checks = 0;
    lo_v = '{32'hA, 32'hF, 32'h32, 32'hFFFFFF9C, 32'h0, 32'h0};
    hi_v = '{32'h14, 32'h1E, 32'h28, 32'hFFFFFFCE, 32'h3E8, 32'hFFFFFF38};
    rows = '{'{2'h1, 32'hA, 4'h1}, '{2'h2, 32'h14, 4'h1}, '{2'h1, 32'hF, 4'h1},
      '{2'h2, 32'h15, 4'h2}, '{2'h1, 32'h2D, 4'h0}, '{2'h2, 32'h1F4, 4'h0},
      '{2'h0, 32'hFFFFFFCE, 4'h4}, '{2'h1, 32'hFFFFFED4, 4'h6}};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // bins 1-4,6,7 on; bin 6 open below, bin 7 open both sides
    wr(`BSC_BIN_EN, 32'h6F);
    wr(`BSC_LO_NOLIM, 32'h3FE0);
    wr(`BSC_HI_NOLIM, 32'h3FC0);
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(`BSC_BIN_LO_BASE + 8'h4 * i, lo_v[i]);
      wr(`BSC_BIN_HI_BASE + 8'h4 * i, hi_v[i]);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      r = rows[i];
      wr(`BSC_CTRL, {26'h0, r.beep, 4'h1});
      judge(r.meas);
      `TB_CHK(bin_hit, (r.bin == 0) ? 14'h0 : 14'h1 << (r.bin - 1), "bin")
      `TB_CHK(no_match, r.bin == 0, "no match")
      `TB_CHK({sec_b, sec_n, sec_a, sec_f}, 4'h0, "sec idle")
      @(negedge clk_i);
      `TB_CHK(beep, (r.beep == 1 && r.bin == 0) || (r.beep == 2 && r.bin != 0), "beep")
      rd(`BSC_RESULT);
      `TB_CHK({q[12], q[4:0]}, {r.bin != 0, r.bin == 0, r.bin}, "result")
      repeat (10) @(posedge clk_i);
    end
    wr(`BSC_REF, 32'h64);
    wr(`BSC_CTRL, 32'h5);
    judge(32'h70);
    `TB_CHK(bin_hit, 14'h1, "deviation")
    // percent deviation 15 lands in bin 1; plain deviation 30 would be bin 2
    wr(`BSC_REF, 32'hC8);
    wr(`BSC_CTRL, 32'h9);
    judge(32'hE6);
    `TB_CHK(bin_hit, 14'h1, "deviation percent")
    wr(`BSC_CTRL, 32'h1);
    wr(`BSC_SEC_HI, 32'h64);
    wr(`BSC_SEC_CTRL, 32'h1);
    wr(`BSC_SEC_MEAS, 32'hC8);
    judge(32'hA);
    `TB_CHK({sec_b, sec_n, sec_a, sec_f, bin_hit}, {4'h3, 14'h1}, "sec above")
    wr(`BSC_SEC_MEAS, 32'h64);
    judge(32'hA);
    `TB_CHK({sec_b, sec_n, sec_a, sec_f}, 4'h4, "sec at upper")
    wr(`BSC_SEC_MEAS, 32'hFFFFFFF6);
    judge(32'hA);
    `TB_CHK({sec_b, sec_n, sec_a, sec_f}, 4'h9, "sec below")
    wr(`BSC_SEC_CTRL, 32'h0);
    judge(32'hA);
    `TB_CHK({sec_b, sec_n, sec_a, sec_f, bin_hit}, {4'h0, 14'h1}, "sec off")
    wr(`BSC_CTRL, 32'h2);
    for (i = 0; i < 3; i = i + 1)
    begin
      judge(32'h5 + 32'hA * i);
      `TB_CHK({pri_b, pri_n, pri_a, bin_hit}, {3'h4 >> i, 14'h0}, "limit")
      rd(`BSC_RESULT);
      `TB_CHK(q[12], i == 1, "limit pass")
    end
    wr(`BSC_CTRL, 32'h1);
    wr(`BSC_BIN_EN, 32'h0);
    judge(32'hF);
    `TB_CHK({no_match, bin_hit}, {1'b1, 14'h0}, "all off")
    // status is set but masked, so the line must stay low
    `TB_CHK(irq, 1'b0, "irq masked")
    rd(`BSC_IRQ_STAT);
    `TB_CHK(q[2:0], 3'h7, "irq status")
    wr(`BSC_IRQ_MASK, 32'h2);
    @(negedge clk_i);
    `TB_CHK(irq, 1'b1, "irq raised")
    wr(`BSC_IRQ_STAT, 32'h7);
    @(negedge clk_i);
    `TB_CHK(irq, 1'b0, "irq cleared")
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C);
    `TB_CHK(q, 32'h0, "unmapped")
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `TB_CHK({irq, beep, no_match, bin_hit, pri_b, pri_n, pri_a}, 20'h0, "reset outputs")
    rd(`BSC_BIN_EN);
    `TB_CHK(q, 32'h1, "bin enable reset")
    rd(`BSC_SEC_CTRL);
    `TB_CHK(q, 32'h7, "secondary reset")
    rd(`BSC_HI_NOLIM);
    `TB_CHK(q, 32'h3FFF, "no-limit reset")
    summarize;
  end
endmodule // bin_sort_comparator_tb
